// >>> rtl/pcm_map.vh
// Register map, field layout, reset values and timing counts of the PLL clock module
`ifndef PCM_MAP_VH
`define PCM_MAP_VH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define PCM_IDX_CLOCK_OUT_PIN_STATUS 16'h7010
`define PCM_IDX_PLL_STATUS 16'h7011
`define PCM_IDX_FAST_PERIPH_PRESCALER 16'h701a
`define PCM_IDX_SLOW_PERIPH_PRESCALER 16'h701b
`define PCM_IDX_PERIPH_CLOCK_GATE_0 16'h701c
`define PCM_IDX_PERIPH_CLOCK_GATE_1 16'h701d
`define PCM_IDX_LOW_POWER_MODE_CONTROL 16'h701e
`define PCM_IDX_PLL_RATIO_CONTROL 16'h7021
`define PCM_IDX_SYSTEM_CONTROL_STATUS 16'h7022
`define PCM_IDX_WATCHDOG_COUNTER 16'h7023
`define PCM_IDX_WATCHDOG_KEY 16'h7025
`define PCM_IDX_WATCHDOG_CONTROL 16'h7029

// ------------------------------------------------------------
// Decoded register slots
// ------------------------------------------------------------
`define PCM_SLOT_NONE 4'h0
`define PCM_SLOT_FIRST_GEN 4'h1
`define PCM_SLOT_LAST_GEN 4'h9
`define PCM_SLOT_WD_COUNTER 4'ha
`define PCM_SLOT_PLL_STATUS 4'hb
`define PCM_SLOT_PLL_RATIO 4'hc

// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define PCM_RATIO_MULT_LSB 0
`define PCM_RATIO_MULT_MSB 3
`define PCM_STS_LOCK_BIT 0
`define PCM_STS_DIVSEL_BIT 1
`define PCM_STS_BUSY_BIT 2
`define PCM_MULT_BYPASS 4'h0
`define PCM_MULT_MAX 4'ha

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PCM_RST_PLL_RATIO 16'h0000
`define PCM_RST_DIVSEL 1'b0
`define PCM_RST_GENERIC 16'h0000

// ------------------------------------------------------------
// Timing, in oscillator clock cycles
// ------------------------------------------------------------
`define PCM_LOCK_CYCLES 131072
`define PCM_LOCK_CNT_W 18

`endif

// >>> rtl/pcm_lock_timer.v
// PLL lock timer: counts the stabilisation time after each ratio write
`timescale 1ns/1ps
`default_nettype none
`include "pcm_map.vh"

module pcm_lock_timer #(
  parameter LOCK_CYCLES = `PCM_LOCK_CYCLES
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst_n,
  // Control
  input wire i_start,
  // Status
  output reg o_locked,
  output wire o_busy
);

  reg [`PCM_LOCK_CNT_W-1:0] cnt_reg;

  assign o_busy = ~o_locked;

  // ------------------------------------------------------------
  // Countdown
  // ------------------------------------------------------------
  // A restart while counting reloads, so lock always follows the last write
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= {`PCM_LOCK_CNT_W{1'b0}};
      o_locked <= 1'b1;
    end else if (i_start) begin
      cnt_reg <= LOCK_CYCLES[`PCM_LOCK_CNT_W-1:0] - 1'b1;
      o_locked <= 1'b0;
    end else if (!o_locked) begin
      if (cnt_reg == {`PCM_LOCK_CNT_W{1'b0}}) begin
        o_locked <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule // pcm_lock_timer
`default_nettype wire

// >>> rtl/pcm_clk_select.v
// Clock ratio selector: bypass or multiplied path, then optional halving
`timescale 1ns/1ps
`default_nettype none
`include "pcm_map.vh"

module pcm_clk_select (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst_n,
  // Configuration
  input wire [3:0] i_mult,
  input wire i_divsel,
  input wire i_locked,
  // Selected ratio
  output reg [3:0] o_mult,
  output reg o_div2,
  output reg o_bypass
);

  wire use_pll;

  // Bypass while the field is zero or while the PLL settles
  assign use_pll = (i_mult != `PCM_MULT_BYPASS) & i_locked;

  // ------------------------------------------------------------
  // Registered ratio
  // ------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mult <= `PCM_MULT_BYPASS;
      o_div2 <= 1'b1;
      o_bypass <= 1'b1;
    end else begin
      o_mult <= use_pll ? i_mult : `PCM_MULT_BYPASS;
      o_div2 <= ~i_divsel;
      o_bypass <= ~use_pll;
    end
  end

endmodule // pcm_clk_select
`default_nettype wire

// >>> rtl/pcm_clock_module.v
// PLL clock module: protected control registers, ratio selection and lock sequencing
`timescale 1ns/1ps
`default_nettype none
`include "pcm_map.vh"

module pcm_clock_module #(
  parameter LOCK_CYCLES = `PCM_LOCK_CYCLES
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst_n,
  // Register port
  input wire [17:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  // CPU protection state
  input wire i_write_protect_enable,
  // Clock ratio to the CPU
  output wire [3:0] o_cpu_input_clock_mult,
  output wire o_cpu_input_clock_div2,
  // Clock ratio of the system clock output
  output wire [3:0] o_system_clock_output_mult,
  output wire o_system_clock_output_div2,
  // Status
  output wire o_pll_bypass,
  output wire o_pll_lock_flag,
  output reg o_write_refused
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function [3:0] slot_of;
    input [17:0] addr;
    begin
      case (addr)
        {`PCM_IDX_CLOCK_OUT_PIN_STATUS, 2'b00}: slot_of = 4'h1;
        {`PCM_IDX_FAST_PERIPH_PRESCALER, 2'b00}: slot_of = 4'h2;
        {`PCM_IDX_SLOW_PERIPH_PRESCALER, 2'b00}: slot_of = 4'h3;
        {`PCM_IDX_PERIPH_CLOCK_GATE_0, 2'b00}: slot_of = 4'h4;
        {`PCM_IDX_PERIPH_CLOCK_GATE_1, 2'b00}: slot_of = 4'h5;
        {`PCM_IDX_LOW_POWER_MODE_CONTROL, 2'b00}: slot_of = 4'h6;
        {`PCM_IDX_SYSTEM_CONTROL_STATUS, 2'b00}: slot_of = 4'h7;
        {`PCM_IDX_WATCHDOG_KEY, 2'b00}: slot_of = 4'h8;
        {`PCM_IDX_WATCHDOG_CONTROL, 2'b00}: slot_of = 4'h9;
        {`PCM_IDX_WATCHDOG_COUNTER, 2'b00}: slot_of = `PCM_SLOT_WD_COUNTER;
        {`PCM_IDX_PLL_STATUS, 2'b00}: slot_of = `PCM_SLOT_PLL_STATUS;
        {`PCM_IDX_PLL_RATIO_CONTROL, 2'b00}: slot_of = `PCM_SLOT_PLL_RATIO;
        default: slot_of = `PCM_SLOT_NONE;
      endcase
    end
  endfunction

  wire [3:0] wr_slot;
  wire [3:0] rd_slot;
  wire wr_mapped;
  wire wr_ok;

  assign wr_slot = slot_of(i_addr);
  assign rd_slot = slot_of(i_addr);
  assign wr_mapped = i_wr & (wr_slot != `PCM_SLOT_NONE);
  // Every register of this block sits in the protected bank
  assign wr_ok = wr_mapped & i_write_protect_enable;

  // ------------------------------------------------------------
  // Refused write indication
  // ------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_write_refused <= 1'b0;
    end else begin
      o_write_refused <= wr_mapped & ~i_write_protect_enable;
    end
  end

  // ------------------------------------------------------------
  // Plain storage registers
  // ------------------------------------------------------------
  // Watchdog key and control, prescaler, gating and low-power registers are held only;
  // their functions live outside this block
  reg [15:0] gen_mem [1:9];

  genvar g;
  generate
    for (g = 1; g <= 9; g = g + 1) begin : g_gen_reg
      always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          gen_mem[g] <= `PCM_RST_GENERIC;
        end else if (wr_ok && (wr_slot == g)) begin
          gen_mem[g] <= i_wdata;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // PLL ratio and status registers
  // ------------------------------------------------------------
  localparam [15:0] RATIO_RST = `PCM_RST_PLL_RATIO;
  reg [3:0] ratio_mult_reg;
  reg divsel_reg;
  wire ratio_wr;
  wire lock_flag;
  wire lock_busy;

  assign ratio_wr = wr_ok & (wr_slot == `PCM_SLOT_PLL_RATIO);

  // Reserved multiplier values are stored unchecked; software keeps them out
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ratio_mult_reg <= RATIO_RST[`PCM_RATIO_MULT_MSB:`PCM_RATIO_MULT_LSB];
    end else if (ratio_wr) begin
      ratio_mult_reg <= i_wdata[`PCM_RATIO_MULT_MSB:`PCM_RATIO_MULT_LSB];
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      divsel_reg <= `PCM_RST_DIVSEL;
    end else if (wr_ok && (wr_slot == `PCM_SLOT_PLL_STATUS)) begin
      divsel_reg <= i_wdata[`PCM_STS_DIVSEL_BIT];
    end
  end

  // ------------------------------------------------------------
  // Lock sequencing
  // ------------------------------------------------------------
  // Any accepted ratio write restarts settling, zero included
  pcm_lock_timer #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_lock_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(ratio_wr),
    .o_locked(lock_flag),
    .o_busy(lock_busy)
  );

  assign o_pll_lock_flag = lock_flag;

  // ------------------------------------------------------------
  // Ratio selection
  // ------------------------------------------------------------
  wire [3:0] sel_mult;
  wire sel_div2;

  pcm_clk_select u_clk_select (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_mult(ratio_mult_reg),
    .i_divsel(divsel_reg),
    .i_locked(lock_flag),
    .o_mult(sel_mult),
    .o_div2(sel_div2),
    .o_bypass(o_pll_bypass)
  );

  assign o_cpu_input_clock_mult = sel_mult;
  assign o_cpu_input_clock_div2 = sel_div2;
  // The system clock output follows the CPU clock with no extra stage
  assign o_system_clock_output_mult = sel_mult;
  assign o_system_clock_output_div2 = sel_div2;

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  reg [15:0] rd_value;

  always @* begin
    rd_value = 16'h0000;
    case (rd_slot)
      `PCM_SLOT_PLL_RATIO: begin
        rd_value[`PCM_RATIO_MULT_MSB:`PCM_RATIO_MULT_LSB] = ratio_mult_reg;
      end
      `PCM_SLOT_PLL_STATUS: begin
        rd_value[`PCM_STS_LOCK_BIT] = lock_flag;
        rd_value[`PCM_STS_DIVSEL_BIT] = divsel_reg;
        rd_value[`PCM_STS_BUSY_BIT] = lock_busy;
      end
      `PCM_SLOT_WD_COUNTER: begin
        rd_value = 16'h0000;
      end
      `PCM_SLOT_NONE: begin
        rd_value = 16'h0000;
      end
      default: begin
        rd_value = gen_mem[rd_slot];
      end
    endcase
  end

  // Read data stands only in the cycle after a read strobe, zero otherwise
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      o_rdata <= rd_value;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule // pcm_clock_module
`default_nettype wire

// >>> tb/pcm_clock_module_chk.sv
// Port checker of the PLL clock module
`timescale 1ns/1ps
`default_nettype none
`include "pcm_map.vh"
module pcm_clock_module_chk #(
  parameter LOCK_CYCLES = 8
) (
  // Clock, reset and register port
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire [17:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] o_rdata,
  input wire i_write_protect_enable,
  // Ratio and status outputs
  input wire [3:0] o_cpu_input_clock_mult,
  input wire o_cpu_input_clock_div2,
  input wire [3:0] o_system_clock_output_mult,
  input wire o_system_clock_output_div2,
  input wire o_pll_bypass,
  input wire o_pll_lock_flag,
  input wire o_write_refused
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  wire ratio_hit = i_addr == {`PCM_IDX_PLL_RATIO_CONTROL, 2'b00};
  wire ratio_ok = i_wr && i_write_protect_enable && ratio_hit;
  logic [17:0] low_cnt;
  sequence s_ratio_wr;
    ratio_ok;
  endsequence
  sequence s_settle;
    !o_pll_lock_flag ##1 (o_pll_bypass && o_cpu_input_clock_mult == 4'h0);
  endsequence
  // A new ratio write restarts the settling count
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) low_cnt <= 18'h00000;
    else if (o_pll_lock_flag || ratio_ok) low_cnt <= 18'h00000;
    else low_cnt <= low_cnt + 18'h00001;
  end
  a_sys_same: assert property (
    o_system_clock_output_mult == o_cpu_input_clock_mult
    && o_system_clock_output_div2 == o_cpu_input_clock_div2) else $error("ratio outputs differ");
  a_refuse_pulse: assert property (
    i_wr && !i_write_protect_enable && ratio_hit |=> o_write_refused) else $error("no refusal");
  a_accept_quiet: assert property (
    s_ratio_wr |=> !o_write_refused) else $error("accepted write refused");
  a_ratio_settle: assert property (
    s_ratio_wr |-> ##1 s_settle) else $error("no bypass after ratio write");
  a_settle_bypass: assert property (
    !o_pll_lock_flag |=> o_pll_bypass) else $error("multiplied before lock");
  a_bypass_mult: assert property (
    o_pll_bypass == (o_cpu_input_clock_mult == 4'h0)) else $error("bypass and mult disagree");
  a_lock_time: assert property (
    $rose(o_pll_lock_flag) |-> low_cnt == LOCK_CYCLES) else $error("lock time wrong");
  a_lock_bound: assert property (
    low_cnt <= LOCK_CYCLES) else $error("lock too late");
  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 16'h0000) else $error("read data outside slot");
endmodule // pcm_clock_module_chk
bind pcm_clock_module pcm_clock_module_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.*);
`default_nettype wire

// >>> tb/tb_pcm_clock_module.sv
// Self-checking bench of the PLL clock module
`timescale 1ns/1ps
`default_nettype none
module tb_pcm_clock_module;
  localparam int LOCK_CYCLES = 8;
  // Watchdog stop pattern; the value is arbitrary, the register only stores it
  localparam logic [15:0] WD_STOP = 16'h0040;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic i_write_protect_enable = 1'b0;
  logic [17:0] i_addr = 18'h00000;
  logic [15:0] i_wdata = 16'h0000;
  wire [15:0] o_rdata;
  wire [3:0] o_cpu_input_clock_mult, o_system_clock_output_mult;
  wire o_cpu_input_clock_div2, o_system_clock_output_div2, o_pll_bypass;
  wire o_pll_lock_flag, o_write_refused;
  logic [15:0] exp_q[$];
  // Last two slots: watchdog counter and an unmapped hole, both read 0
  logic [15:0] idx_t [11] = '{16'h7010, 16'h701a, 16'h701b, 16'h701c, 16'h701d,
    16'h701e, 16'h7022, 16'h7025, 16'h7029, 16'h7023, 16'h7012};
  logic [3:0] mult_t [4] = '{4'h5, 4'ha, 4'h1, 4'h0};
  logic [31:0] seed = 32'h0000f531;
  int bad_count = 0, checked = 0, cyc = 0;
  logic rd_d = 1'b0;

  pcm_clock_module #(.LOCK_CYCLES(LOCK_CYCLES)) uut (.*);

  always #4 i_clk_sys = ~i_clk_sys;

  // ----
  // Helpers
  // ----
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic p);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= {idx, 2'b00};
    i_wdata <= d;
    i_write_protect_enable <= p;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [15:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= {idx, 2'b00};
    exp_q.push_back(e);
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
  endtask

  task automatic outs(input logic [3:0] m, input logic b, input logic l, input logic d2);
    check({9'h000, o_cpu_input_clock_mult, o_pll_bypass, o_pll_lock_flag,
      o_cpu_input_clock_div2}, {9'h000, m, b, l, d2});
    check({11'h000, o_system_clock_output_mult, o_system_clock_output_div2},
      {11'h000, m, d2});
  endtask

  // Read data is due in the cycle after the strobe only
  always @(posedge i_clk_sys) begin
    rd_d <= i_rd;
    cyc <= cyc + 1;
    if (rd_d) check(o_rdata, exp_q.pop_front());
    if (cyc > 3000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ----
  // Sequence
  // ----
  initial begin
    logic [15:0] d;
    logic [15:0] msk;
    repeat (5) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    #1 outs(4'h0, 1'b1, 1'b1, 1'b1);
    for (int k = 0; k < 11; k++) begin
      d = rnd();
      msk = (k < 9) ? 16'hffff : 16'h0000;
      wr(idx_t[k], d, 1'b1);
      rd(idx_t[k], d & msk);
      wr(idx_t[k], ~d, 1'b0);
      #1 check({15'h0, o_write_refused}, {15'h0, k < 10});
      rd(idx_t[k], d & msk);
    end
    for (int k = 0; k < 4; k++) begin
      d = rnd();
      wr(16'h7029, WD_STOP, 1'b1);
      wr(16'h7011, 16'h0000, 1'b1);
      wr(16'h7021, 16'h0003, 1'b1);
      repeat (3) @(posedge i_clk_sys);
      // Second write mid-settling restarts the count
      wr(16'h7021, {d[15:4], mult_t[k]}, 1'b1);
      repeat (LOCK_CYCLES - 1) @(posedge i_clk_sys);
      #1 outs(4'h0, 1'b1, 1'b0, 1'b1);
      repeat (2) @(posedge i_clk_sys);
      #1 outs(mult_t[k], mult_t[k] == 4'h0, 1'b1, 1'b1);
      rd(16'h7021, {12'h000, mult_t[k]});
      rd(16'h7011, 16'h0001);
      wr(16'h7011, 16'h0002, 1'b1);
      @(posedge i_clk_sys);
      #1 outs(mult_t[k], mult_t[k] == 4'h0, 1'b1, 1'b0);
      rd(16'h7011, 16'h0003);
      wr(16'h7021, 16'h0004, 1'b0);
      #1 outs(mult_t[k], mult_t[k] == 4'h0, 1'b1, 1'b0);
      rd(16'h7021, {12'h000, mult_t[k]});
    end
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    #1 outs(4'h0, 1'b1, 1'b1, 1'b1);
    rd(16'h7021, 16'h0000);
    rd(16'h701a, 16'h0000);
    rd(16'h7011, 16'h0001);
    repeat (3) @(posedge i_clk_sys);
    wrap_up();
  end
endmodule // tb_pcm_clock_module
`default_nettype wire
